// [src/timer_pkg.sv]
`default_nettype none
package timer_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int IDX_W = 16;
	localparam int PRE_W = 12;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_MODE0 = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_CYCLE0 = 16'h0001;
	localparam logic [IDX_W-1:0] IDX_DUTY0 = 16'h0002;
	localparam logic [IDX_W-1:0] IDX_MODE1 = 16'h0003;
	localparam logic [IDX_W-1:0] IDX_CYCLE1 = 16'h0004;
	localparam logic [IDX_W-1:0] IDX_DUTY1 = 16'h0005;
	localparam logic [IDX_W-1:0] IDX_CARRIER = 16'h0006;
	localparam logic [IDX_W-1:0] IDX_COUNT0 = 16'h0007;
	localparam logic [IDX_W-1:0] IDX_COUNT1 = 16'h0008;
	localparam logic [IDX_W-1:0] IDX_PORT1_DIR = 16'hff21;

	// mode_control_reg fields
	localparam int MD_EN = 7;
	localparam int MD_CKS_HI = 6;
	localparam int MD_CKS_LO = 4;
	localparam int MD_MODE_HI = 3;
	localparam int MD_MODE_LO = 2;
	localparam int MD_LEV = 1;
	localparam int MD_OE = 0;

	// carrier control fields
	localparam int CC_RMC = 2;
	localparam int CC_NRZB = 1;
	localparam int CC_NRZ = 0;

	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] PORT1_DIR_RESET = 8'hff;
	localparam int TIMER_PIN0 = 5;
	localparam int TIMER_PIN1 = 6;

	localparam logic [1:0] MODE_INTERVAL = 2'h0;
	localparam logic [1:0] MODE_CARRIER = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;

	// count clock ticks a buffered compare must age before transfer
	localparam logic [1:0] XFER_MIN_TICKS = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {
		R_MODE0, R_CYCLE0, R_DUTY0, R_MODE1, R_CYCLE1, R_DUTY1,
		R_CARRIER, R_COUNT0, R_COUNT1, R_PORT1_DIR, R_NONE
	} reg_e;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] cycle;
		logic [7:0] duty_buf;
		logic [7:0] duty_act;
		logic [7:0] cnt;
		logic duty_phase;
		logic masked;
		logic active;
		logic irq;
		logic pend;
		logic [1:0] age;
		logic pin;
	} chan_s;

	// prescaler tap for each count clock select code
	function automatic logic [3:0] div_exp(input logic [2:0] sel);
		unique case (sel)
			3'h0: div_exp = 4'h0;
			3'h1: div_exp = 4'h2;
			3'h2: div_exp = 4'h4;
			3'h3: div_exp = 4'h6;
			3'h4: div_exp = 4'ha;
			3'h5: div_exp = 4'h7;
			3'h6: div_exp = 4'h9;
			3'h7: div_exp = 4'hc;
		endcase
	endfunction

endpackage
`default_nettype wire

// [src/count_prescaler.sv]
`default_nettype none
module count_prescaler #(
	parameter int PRE_W = timer_pkg::PRE_W
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	output logic [PRE_W:0] tick // tick[k] pulses once per 2**k clocks
);
	import timer_pkg::*;

	typedef struct packed {
		logic [PRE_W-1:0] cnt;
	} pre_s;

	pre_s st_ff;
	pre_s nxt_st;

	if (PRE_W < 1 || PRE_W > 15) begin : g_bad_width
		$error("count_prescaler: PRE_W out of range");
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnt = st_ff.cnt + {{(PRE_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		tick[0] = 1'b1;
		for (int k = 1; k <= PRE_W; k++) begin
			tick[k] = &(st_ff.cnt | ~PRE_W'((1 << k) - 1));
		end
	end

endmodule // count_prescaler
`default_nettype wire

// [src/compare_timer.sv]
// Notes on behaviour
// RULE1: interval match raises irq, clears counter
// RULE2: interval mode ignores duty compare entirely
// RULE3: output enabled: toggle per cycle match
// RULE4: counting starts within one count clock
// RULE5: stopping forces irq and output inactive
// RULE6: software keeps cycle compare fixed in pwm
// RULE7: pwm cycle match clears, irqs, activates, switches
// RULE8: pwm duty match deactivates, switches, no clear
// RULE9: pwm period N+1, active width M+1
// RULE10: running duty writes buffered until old match
// RULE11: buffered duty needs three count clocks age
// RULE12: software rewrites duty after each restart
// RULE13: software keeps duty below cycle, both bytes
// RULE14: pwm start masks first count clock
// RULE15: carrier: first compare low, second high
// RULE16: software keeps carrier low compare fixed
// RULE17: event counter gates carrier onto pin
// RULE18: direction bit 0 drives pin, resets ones
// RULE19: software clears direction bits five, six
// RULE20: enable low holds counter cleared, stopped
// RULE21: running: only enable bit of mode changes
// RULE22: level bit sets inactive level, inverts
//
// Added by the designer: register access over AXI4-Lite.
`default_nettype none
module compare_timer #(
	parameter int ADDR_W = timer_pkg::ADDR_W,
	parameter int PRE_W = timer_pkg::PRE_W
) (
	input wire logic aclk, // system clock, 10 MHz
	input wire logic aresetn, // sync reset, active low
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [ADDR_W-1:0] awaddr, // write byte address
	input wire logic [2:0] awprot, // unused
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [timer_pkg::DATA_W-1:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [ADDR_W-1:0] araddr, // read byte address
	input wire logic [2:0] arprot, // unused
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [timer_pkg::DATA_W-1:0] rdata, // read data
	output logic [1:0] rresp, // read response
	input wire logic carrier_event, // event counter interrupt pulse
	output logic [1:0] match_irq, // per-timer match pulse
	output logic [1:0] timer_out_pin, // timer pin levels
	output logic [1:0] timer_out_oe, // timer pin drive enables
	output logic [7:0] port1_oe // port 1 output buffer enables
);
	import timer_pkg::*;

	typedef struct packed {
		chan_s [1:0] ch;
		logic [7:0] port1_direction;
		logic rmc;
		logic nrzb;
		logic nrz;
		logic evt_seen;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} state_s;

	state_s st_ff;
	state_s nxt_st;
	logic [PRE_W:0] pre_tick;
	logic [1:0] cnt_tick;

	if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr
		$error("compare_timer: ADDR_W must hold index 16'hff21");
	end
	if (PRE_W < 12) begin : g_bad_pre
		$error("compare_timer: PRE_W too small for count clocks");
	end

	function automatic reg_e reg_sel(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-3:0] idx;
		idx = addr[ADDR_W-1:2];
		reg_sel = R_NONE;
		if (idx == (ADDR_W-2)'(IDX_MODE0)) reg_sel = R_MODE0;
		if (idx == (ADDR_W-2)'(IDX_CYCLE0)) reg_sel = R_CYCLE0;
		if (idx == (ADDR_W-2)'(IDX_DUTY0)) reg_sel = R_DUTY0;
		if (idx == (ADDR_W-2)'(IDX_MODE1)) reg_sel = R_MODE1;
		if (idx == (ADDR_W-2)'(IDX_CYCLE1)) reg_sel = R_CYCLE1;
		if (idx == (ADDR_W-2)'(IDX_DUTY1)) reg_sel = R_DUTY1;
		if (idx == (ADDR_W-2)'(IDX_CARRIER)) reg_sel = R_CARRIER;
		if (idx == (ADDR_W-2)'(IDX_COUNT0)) reg_sel = R_COUNT0;
		if (idx == (ADDR_W-2)'(IDX_COUNT1)) reg_sel = R_COUNT1;
		if (idx == (ADDR_W-2)'(IDX_PORT1_DIR)) reg_sel = R_PORT1_DIR;
	endfunction

	count_prescaler #(.PRE_W(PRE_W)) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(pre_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// count clock enable per timer from its select field
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cnt_tick[i] = pre_tick[div_exp(
				st_ff.ch[i].mode[MD_CKS_HI:MD_CKS_LO])];
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		chan_s c;
		chan_s n;
		logic run;
		logic [1:0] md;
		logic xfer_ok;
		logic wr_fire;
		logic rd_fire;
		reg_e wsel;
		reg_e rsel;
		logic [7:0] rbyte;
		logic carrier_on;
		c = '0;
		n = '0;
		run = 1'b0;
		md = MODE_INTERVAL;
		xfer_ok = 1'b0;
		carrier_on = 1'b0;
		rbyte = 8'h00;
		wr_fire = 1'b0;
		rd_fire = 1'b0;
		wsel = R_NONE;
		rsel = R_NONE;
		nxt_st = st_ff;

		// bus: address and data taken in either order
		if (awvalid && awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = wdata[7:0];
			nxt_st.w_lane0 = wstrb[0];
		end
		wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
		wsel = reg_sel(st_ff.aw_addr);
		if (wr_fire) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = (wsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end
		wr_fire = wr_fire && st_ff.w_lane0 && (wsel != R_NONE);

		// carrier event latched until timer 1 next counts
		if (cnt_tick[1] && st_ff.evt_seen) begin
			nxt_st.nrz = st_ff.nrzb; // RULE17
			nxt_st.evt_seen = 1'b0;
		end
		if (carrier_event) begin
			nxt_st.evt_seen = 1'b1;
		end

		for (int i = 0; i < 2; i++) begin
			c = st_ff.ch[i];
			n = c;
			run = c.mode[MD_EN];
			md = c.mode[MD_MODE_HI:MD_MODE_LO];
			if (md == MODE_CARRIER && i == 0) begin
				md = MODE_INTERVAL;
			end
			if (md != MODE_PWM && md != MODE_CARRIER) begin
				md = MODE_INTERVAL;
			end
			xfer_ok = c.pend && (c.age >= XFER_MIN_TICKS - 2'h1); // RULE11
			n.irq = 1'b0;
			if (!run) begin
				n.cnt = 8'h00; // RULE20
				n.duty_phase = 1'b0;
				n.masked = 1'b1;
				n.active = 1'b0; // RULE5
				n.pend = 1'b0;
				n.age = 2'h0;
			end else if (cnt_tick[i]) begin // RULE4
				if (c.pend && c.age != 2'h3) begin
					n.age = c.age + 2'h1;
				end
				if (c.masked && md == MODE_PWM) begin
					n.masked = 1'b0; // RULE14
				end else begin
					unique case (md)
						MODE_INTERVAL: begin
							// duty compare is never looked at here
							if (c.cnt == c.cycle) begin // RULE2
								n.cnt = 8'h00; // RULE1
								n.irq = 1'b1;
								if (c.mode[MD_OE]) begin
									n.active = !c.active; // RULE3
								end
							end else begin
								n.cnt = c.cnt + 8'h01;
							end
						end
						MODE_PWM: begin
							if (!c.duty_phase) begin
								if (c.cnt == c.cycle) begin // RULE9
									n.cnt = 8'h00; // RULE7
									n.irq = 1'b1;
									n.active = 1'b1;
									n.duty_phase = 1'b1;
								end else begin
									n.cnt = c.cnt + 8'h01;
								end
							end else begin
								n.cnt = c.cnt + 8'h01; // RULE8
								if (c.cnt == c.duty_act) begin
									n.active = 1'b0;
									n.duty_phase = 1'b0;
									if (xfer_ok) begin
										n.duty_act = c.duty_buf; // RULE10
										n.pend = 1'b0;
									end
								end
							end
						end
						MODE_CARRIER: begin
							// low phase on cycle, high phase on duty
							if (c.cnt == (c.duty_phase ? c.duty_act
								: c.cycle)) begin // RULE15
								n.cnt = 8'h00;
								n.irq = 1'b1;
								n.active = !c.active;
								n.duty_phase = !c.duty_phase;
								if (c.duty_phase && xfer_ok) begin
									n.duty_act = c.duty_buf;
									n.pend = 1'b0;
								end
							end else begin
								n.cnt = c.cnt + 8'h01;
							end
						end
						default: begin
							n.cnt = c.cnt;
						end
					endcase
				end
			end

			// register writes
			if (wr_fire && ((i == 0 && wsel == R_MODE0)
				|| (i == 1 && wsel == R_MODE1))) begin
				if (run) begin
					n.mode[MD_EN] = st_ff.w_data[MD_EN]; // RULE21
				end else begin
					n.mode = st_ff.w_data;
				end
			end
			if (wr_fire && ((i == 0 && wsel == R_CYCLE0)
				|| (i == 1 && wsel == R_CYCLE1))) begin
				n.cycle = st_ff.w_data;
			end
			if (wr_fire && ((i == 0 && wsel == R_DUTY0)
				|| (i == 1 && wsel == R_DUTY1))) begin
				n.duty_buf = st_ff.w_data;
				if (run && md != MODE_INTERVAL) begin
					n.pend = 1'b1; // RULE10
					n.age = 2'h0;
				end else begin
					n.duty_act = st_ff.w_data;
					n.pend = 1'b0;
				end
			end

			// pin level: level bit is the inactive level
			carrier_on = (i == 1) && (md == MODE_CARRIER);
			if (!n.mode[MD_EN] || !n.mode[MD_OE]) begin
				n.pin = n.mode[MD_LEV]; // RULE5
			end else if (carrier_on) begin
				n.pin = nxt_st.nrz && (!st_ff.rmc
					|| (n.mode[MD_LEV] ^ n.active)); // RULE17
			end else begin
				n.pin = n.mode[MD_LEV] ^ n.active; // RULE22
			end
			nxt_st.ch[i] = n;
		end

		if (wr_fire && wsel == R_CARRIER) begin
			nxt_st.rmc = st_ff.w_data[CC_RMC];
			nxt_st.nrzb = st_ff.w_data[CC_NRZB];
		end
		if (wr_fire && wsel == R_PORT1_DIR) begin
			nxt_st.port1_direction = st_ff.w_data; // RULE18
		end

		// read channel
		rd_fire = arvalid && arready;
		rsel = reg_sel(araddr);
		unique case (rsel)
			R_MODE0: rbyte = st_ff.ch[0].mode;
			R_CYCLE0: rbyte = st_ff.ch[0].cycle;
			R_DUTY0: rbyte = st_ff.ch[0].duty_buf;
			R_MODE1: rbyte = st_ff.ch[1].mode;
			R_CYCLE1: rbyte = st_ff.ch[1].cycle;
			R_DUTY1: rbyte = st_ff.ch[1].duty_buf;
			R_CARRIER: rbyte = {5'h00, st_ff.rmc, st_ff.nrzb, st_ff.nrz};
			R_COUNT0: rbyte = st_ff.ch[0].cnt;
			R_COUNT1: rbyte = st_ff.ch[1].cnt;
			R_PORT1_DIR: rbyte = st_ff.port1_direction;
			R_NONE: rbyte = 8'h00;
		endcase
		if (rd_fire) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = {24'h000000, rbyte};
			nxt_st.rresp = (rsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			for (int i = 0; i < 2; i++) begin
				st_ff.ch[i].mode <= MODE_RESET;
				st_ff.ch[i].cycle <= CMP_RESET;
				st_ff.ch[i].duty_buf <= CMP_RESET;
				st_ff.ch[i].duty_act <= CMP_RESET;
				st_ff.ch[i].masked <= 1'b1;
			end
			st_ff.port1_direction <= PORT1_DIR_RESET; // RULE18
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign awready = !st_ff.aw_held && !st_ff.bvalid;
	assign wready = !st_ff.w_held && !st_ff.bvalid;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = !st_ff.rvalid;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign match_irq = {st_ff.ch[1].irq, st_ff.ch[0].irq};
	assign timer_out_pin = {st_ff.ch[1].pin, st_ff.ch[0].pin};
	assign port1_oe = ~st_ff.port1_direction; // RULE18
	assign timer_out_oe = {!st_ff.port1_direction[TIMER_PIN1],
		!st_ff.port1_direction[TIMER_PIN0]};

endmodule // compare_timer
`default_nettype wire

// [verification/compare_timer_props.sv]
`default_nettype none
module compare_timer_props (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic awvalid, // aw valid
	input wire logic awready, // aw ready
	input wire logic wvalid, // w valid
	input wire logic wready, // w ready
	input wire logic bvalid, // b valid
	input wire logic bready, // b ready
	input wire logic [1:0] bresp, // b resp
	input wire logic arvalid, // ar valid
	input wire logic arready, // ar ready
	input wire logic rvalid, // r valid
	input wire logic rready, // r ready
	input wire logic [timer_pkg::DATA_W-1:0] rdata, // r data
	input wire logic [1:0] match_irq, // match pulses
	input wire logic [1:0] timer_out_oe, // pin enables
	input wire logic [7:0] port1_oe // port enables
);
	timeunit 1ns;
	timeprecision 1ns;
	import timer_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_reset_vals: assert property ($rose(aresetn) |->
		port1_oe == 8'h00 && timer_out_oe == 2'h0 && match_irq == 2'h0
		&& !bvalid && !rvalid) else $error("outputs off reset values");
	a_oe_from_dir: assert property (timer_out_oe ==
		{port1_oe[TIMER_PIN1], port1_oe[TIMER_PIN0]})
		else $error("timer pin enable off direction");
	a_b_hold: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp)) else $error("write response dropped");
	a_r_hold: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata)) else $error("read data dropped");
	a_ar_ready: assert property (arready == !rvalid)
		else $error("arready not inverse of rvalid");
	a_rdata_top: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read upper bits not zero");
	a_write_resp: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write response late");
	a_read_resp: assert property (arvalid && arready |=> rvalid)
		else $error("read response late");
	a_b_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	c_irq0: cover property (match_irq[0]);
	c_irq1: cover property (match_irq[1]);
	c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule // compare_timer_props
////////////////////////////////////////
bind compare_timer compare_timer_props compare_timer_props_inst (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .match_irq(match_irq),
	.timer_out_oe(timer_out_oe), .port1_oe(port1_oe));
`default_nettype wire

// [verification/compare_timer_tb.sv]
`default_nettype none
module compare_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import timer_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic carrier_event, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, match_irq, timer_out_pin, timer_out_oe;
	logic [7:0] port1_oe, v;
	logic [7:0] port_val;
	logic [1:0] r;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	int err_total = 0;
	int check_count = 0;
	compare_timer compare_timer_inst (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .carrier_event(carrier_event),
		.match_irq(match_irq), .timer_out_pin(timer_out_pin),
		.timer_out_oe(timer_out_oe), .port1_oe(port1_oe));
	always #50 aclk = ~aclk;
	////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [IDX_W-1:0] ri(input int ch, k);
		return IDX_MODE0 + IDX_W'(3 * ch + k);
	endfunction
	task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d,
		output logic [1:0] rs);
		bit a, w, b;
		b = 0;
		@(posedge aclk);
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !b; n++) begin
			@(negedge aclk);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
		if (!b) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic rd(input logic [IDX_W-1:0] i, output logic [7:0] d,
		output logic [1:0] rs);
		bit a, b;
		b = 0;
		@(posedge aclk);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !b; n++) begin
			@(negedge aclk);
			a = arvalid && arready;
			b = rvalid;
			d = rdata[7:0];
			rs = rresp;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
			if (b) rready <= 1'b0;
		end
		if (!b) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic span(input int ch, input bit pn, input logic l,
		output int c);
		logic s;
		c = 0;
		do begin
			@(negedge aclk);
			c++;
			s = pn ? timer_out_pin[ch] : match_irq[ch];
		end while (s !== l && c < 2000);
		if (s !== l) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic stop(input int ch, input logic [7:0] md);
		int h;
		h = 0;
		wr(ri(ch, 0), {1'b0, md[6:0]}, r);
		repeat (40) begin
			@(negedge aclk);
			if (match_irq[ch] !== 1'b0) h++;
		end
		chk("stopped irq", h, 0);
		chk("stopped pin", timer_out_pin[ch], md[1]);
		rd(IDX_COUNT0 + IDX_W'(ch), v, r);
		chk("stopped count", v, 0);
	endtask
	////////////////////////////////////////
	task automatic intv(input int ch, input logic [2:0] sel, input logic l);
		logic [7:0] n;
		logic p;
		int c1, c2;
		int t;
		n = 8'($urandom_range(1, 6));
		t = (n + 1) << (2 * sel);
		wr(ri(ch, 1), n, r);
		wr(ri(ch, 2), 8'h00, r);
		wr(ri(ch, 0), {1'b1, sel, MODE_INTERVAL, l, 1'b1}, r);
		span(ch, 0, 1'b1, c1);
		chk("start", c1 <= t && c1 > t - (1 << 2 * sel), 1);
		for (int k = 0; k < 3; k++) begin
			p = timer_out_pin[ch];
			span(ch, 0, 1'b0, c1);
			span(ch, 0, 1'b1, c2);
			chk("interval gap", c1 + c2, (n + 1) << (2 * sel));
			chk("square pin", timer_out_pin[ch], !p);
		end
		stop(ch, {1'b1, sel, MODE_INTERVAL, l, 1'b1});
	endtask
	task automatic pwm(input int ch, input logic l);
		logic [7:0] n, m, m2;
		int c1, c2;
		n = 8'($urandom_range(12, 20));
		m = 8'($urandom_range(0, 3));
		m2 = 8'($urandom_range(4, 10));
		wr(ri(ch, 1), n, r);
		wr(ri(ch, 2), m, r);
		wr(ri(ch, 0), {1'b1, 3'h0, MODE_PWM, l, 1'b1}, r);
		@(negedge aclk);
		chk("pwm start pin", timer_out_pin[ch], l);
		span(ch, 0, 1'b1, c1);
		chk("pwm first match", c1, n + 1);
		chk("pwm active", timer_out_pin[ch], !l);
		span(ch, 1, l, c1);
		span(ch, 0, 1'b1, c2);
		chk("pwm width", c1, m + 1);
		chk("pwm period", c1 + c2, n + 1);
		span(ch, 1, l, c1);
		wr(ri(ch, 2), m2, r);
		span(ch, 0, 1'b1, c2);
		span(ch, 1, l, c1);
		chk("old duty width", c1, m + 1);
		span(ch, 0, 1'b1, c2);
		span(ch, 1, l, c1);
		chk("new duty width", c1, m2 + 1);
		stop(ch, {1'b1, 3'h0, MODE_PWM, l, 1'b1});
	endtask
	task automatic carrier;
		logic [7:0] n, m;
		int c, h;
		n = 8'($urandom_range(2, 6));
		m = 8'($urandom_range(2, 6));
		h = 0;
		wr(IDX_CYCLE1, n, r);
		wr(IDX_DUTY1, m, r);
		wr(IDX_CARRIER, 8'h06, r);
		wr(IDX_MODE1, {1'b1, 3'h0, MODE_CARRIER, 1'b0, 1'b1}, r);
		repeat (30) begin
			@(negedge aclk);
			if (timer_out_pin[1] !== 1'b0) h++;
		end
		chk("carrier gated", h, 0);
		@(posedge aclk);
		carrier_event <= 1'b1;
		@(posedge aclk);
		carrier_event <= 1'b0;
		span(1, 1, 1'b1, c);
		span(1, 1, 1'b0, c);
		span(1, 1, 1'b1, c);
		chk("carrier low", c, n + 1);
		span(1, 1, 1'b0, c);
		chk("carrier high", c, m + 1);
		stop(1, {1'b1, 3'h0, MODE_CARRIER, 1'b0, 1'b1});
	endtask
	////////////////////////////////////////
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{carrier_event, awaddr, araddr, wdata} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(89));
		rd(IDX_PORT1_DIR, v, r);
		chk("direction reset", v, PORT1_DIR_RESET);
		chk("port oe reset", port1_oe, 8'h00);
		port_val = 8'($urandom);
		wr(IDX_PORT1_DIR, port_val, r);
		rd(IDX_PORT1_DIR, v, r);
		chk("direction readback", v, port_val);
		chk("port oe", port1_oe, port_val ^ 8'hff);
		chk("timer oe", timer_out_oe, {~v[6], ~v[5]});
		wr(IDX_PORT1_DIR, 8'h9f, r);
		chk("timer oe on", timer_out_oe, 2'h3);
		wr(16'h0009, 8'h12, r);
		chk("unmapped write", r, RESP_SLVERR);
		rd(16'h0009, v, r);
		chk("unmapped read", r, RESP_SLVERR);
		chk("unmapped data", v, 8'h00);
		intv(0, 3'h0, 1'b0);
		intv(1, 3'h1, 1'b1);
		pwm(0, 1'b0);
		pwm(0, 1'b1);
		pwm(1, 1'b0);
		carrier();
		close_out();
	end
endmodule // compare_timer_tb
`default_nettype wire
